// ---- verilog/smbus_byte_access_control_regs.sv ----
// serial byte access and control registers of the differential clock buffer
//
// Overview of operation
// - A byte write is start, address with write bit, command, data, stop, each byte acked.
// - A byte read repeats start after the command and the device acks and returns one byte.
// - A command with its top bit set is a byte access whose low seven bits give the offset.
// - Mode bits 7 and 6 pick driven or three-state outputs for power-down and clock stop.
// - Mode bit 2 picks high (0) or low (1) loop bandwidth and powers up as one.
// - Mode bit 1 picks fan-out bypass (0) or loop mode (1) and powers up as one.
// - Mode bit 0 picks half rate (0) or full rate (1) and powers up as one.
// - Enable bits 6, 5, 2, 1 each enable one output pair, three-state at zero, reset to one.
// - The pair enable register powers up all ones and the mode register as 0x07.
// - Reserved bits are stored as written and read back, but steer nothing.
// - Only the address byte 0xdc (0xdd for reads) is answered.
// - Power-down with drive mode zero holds true high at double current, comp off.
`timescale 1ns/1ps
`default_nettype none
`include "cbuf_params.svh"
module smbus_byte_access_control_regs
   import cbuf_pkg::*;
(
   // system clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // serial control link
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // power management pins
   input  wire logic        power_down_n_i,
   input  wire logic        ref_clock_stop_n_i,
   input  wire logic [3:0]  pair_stoppable_i,
   // control outputs
   output mode_ctrl_s       mode_o,
   output logic [3:0]       diff_pair_en_o,
   output pair_drive_s [3:0] pair_drive_o
);

   // system domain state
   logic [7:0]  bmc_q;
   logic [7:0]  pe_q;
   logic        pd_n_s;
   logic        stop_n_s;
   logic        wr_tgl_s;
   logic        wr_seen_q;

   // link domain state
   logic        link_rst_s;
   logic        sda_r_q;
   logic        start_tgl_q;
   logic        start_ack_q;
   link_state_e state_q;
   link_state_e state_d;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic [7:0]  tx_q;
   logic [7:0]  tx_d;
   logic        oe_q;
   logic        oe_d;
   logic        have_cmd_q;
   logic        have_cmd_d;
   logic [6:0]  off_q;
   logic [6:0]  off_d;
   logic [7:0]  wr_data_q;
   logic [7:0]  wr_data_d;
   logic        wr_tgl_q;
   logic        wr_tgl_d;

   // ---------------- system clock side ----------------
   sync2 u_pd_sync (
      .clk_i (sys_clk_i),
      .d_i   (power_down_n_i),
      .q_o   (pd_n_s)
   );

   sync2 u_stop_sync (
      .clk_i (sys_clk_i),
      .d_i   (ref_clock_stop_n_i),
      .q_o   (stop_n_s)
   );

   // write event crosses as a toggle; offset and data are held by the link side
   sync2 u_wr_sync (
      .clk_i (sys_clk_i),
      .d_i   (wr_tgl_q),
      .q_o   (wr_tgl_s)
   );

   wire wr_pulse_w   = wr_tgl_s ^ wr_seen_q;
   wire wr_mode_w    = wr_pulse_w && (off_q == `OFF_BUF_MODE);
   wire wr_pair_w    = wr_pulse_w && (off_q == `OFF_PAIR_EN);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         bmc_q     <= `RST_BUF_MODE;
         pe_q      <= `RST_PAIR_EN;
         wr_seen_q <= 1'b0;
      end else begin
         wr_seen_q <= wr_tgl_s;
         if (wr_mode_w) begin
            bmc_q <= wr_data_q;
         end
         if (wr_pair_w) begin
            pe_q <= wr_data_q;
         end
      end
   end

   // reserved bits are stored but feed nothing
   assign mode_o.pd_tristate       = bmc_q[`BM_PD_TRI];
   assign mode_o.stop_tristate     = bmc_q[`BM_STOP_TRI];
   assign mode_o.pll_bandwidth_sel = bmc_q[`BM_PLL_BW];
   assign mode_o.pll_mode          = bmc_q[`BM_PLL_MODE];
   assign mode_o.half_rate_sel     = bmc_q[`BM_HALF_RATE];

   wire [3:0] pair_en_w = {pe_q[`PE_PAIR6], pe_q[`PE_PAIR5],
                           pe_q[`PE_PAIR2], pe_q[`PE_PAIR1]};
   assign diff_pair_en_o = pair_en_w;

   wire [3:0] true_oe_w;
   wire [3:0] comp_oe_w;
   wire [3:0] held_w;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pair
         pair_drive u_pair (
            .sys_clk_i     (sys_clk_i),
            .rst_i         (rst_i),
            .pair_en_i     (pair_en_w[gi]),
            .stoppable_i   (pair_stoppable_i[gi]),
            .pd_active_i   (!pd_n_s),
            .stop_active_i (!stop_n_s),
            .pd_tri_i      (bmc_q[`BM_PD_TRI]),
            .stop_tri_i    (bmc_q[`BM_STOP_TRI]),
            .drive_o       (pair_drive_o[gi])
         );
         assign true_oe_w[gi] = pair_drive_o[gi].true_oe;
         assign comp_oe_w[gi] = pair_drive_o[gi].comp_oe;
         assign held_w[gi]    = pair_drive_o[gi].true_held;
      end
   endgenerate

   // read data is quasi-static: it only changes after a write the link itself made
   wire [7:0] rd_byte_w = (off_q == `OFF_BUF_MODE) ? bmc_q :
                          (off_q == `OFF_PAIR_EN)  ? pe_q  : 8'h00;
   wire       rd_msb_w  = rd_byte_w[7];

   // ---------------- link clock side ----------------
   sync2 u_link_rst (
      .clk_i (scl_i),
      .d_i   (rst_i),
      .q_o   (link_rst_s)
   );

   // data is sampled while clock is high, so it is protocol-timed, not synchronised
   always_ff @(posedge scl_i) begin
      if (link_rst_s) begin
         sda_r_q <= 1'b1;
      end else begin
         sda_r_q <= sda_i;
      end
   end

   // a start right after a stop has no clock edge between them, so data falling
   // while the clock is high is caught on the data edge itself and handed over as a toggle
   always_ff @(negedge sda_i or posedge link_rst_s) begin
      if (link_rst_s) begin
         start_tgl_q <= 1'b0;
      end else if (scl_i) begin
         start_tgl_q <= !start_tgl_q;
      end
   end

   wire [7:0] byte_w     = {sh_q[6:0], sda_r_q};
   wire       restart_w  = start_tgl_q ^ start_ack_q;  // start or repeated start seen
   wire       last_bit_w = (cnt_q == `LAST_BIT);
   wire       ack_slot_w = (cnt_q == `ACK_SLOT);
   wire       addr_wr_w  = (byte_w == {`SLAVE_ADDR7, `DIR_WRITE});
   wire       addr_rd_w  = (byte_w == {`SLAVE_ADDR7, `DIR_READ});
   wire       byte_op_w  = byte_w[`CMD_BYTE_OP];
   wire       rx_state_w = (state_q == LS_ADDR) || (state_q == LS_CMD) ||
                           (state_q == LS_WDATA);

   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      sh_d       = sh_q;
      tx_d       = tx_q;
      oe_d       = oe_q;
      have_cmd_d = have_cmd_q;
      off_d      = off_q;
      wr_data_d  = wr_data_q;
      wr_tgl_d   = wr_tgl_q;
      if (restart_w || state_q == LS_IDLE) begin
         // first falling clock of a frame; only a repeated start keeps the command
         state_d    = LS_ADDR;
         cnt_d      = 4'h0;
         oe_d       = 1'b0;
         have_cmd_d = (state_q == LS_WDATA) && have_cmd_q;
      end else if (rx_state_w && ack_slot_w) begin
         oe_d  = 1'b0;
         cnt_d = 4'h0;
      end else if (rx_state_w && !last_bit_w) begin
         sh_d  = byte_w;
         cnt_d = cnt_q + 4'h1;
      end else begin
         case (state_q)
            LS_ADDR: begin
               cnt_d = `ACK_SLOT;
               if (addr_wr_w) begin
                  state_d = LS_CMD;
                  oe_d    = 1'b1;
               end else if (addr_rd_w && have_cmd_q) begin
                  state_d = LS_RDATA;
                  oe_d    = 1'b1;
               end else begin
                  state_d = LS_IGNORE;
                  oe_d    = 1'b0;
               end
            end
            LS_CMD: begin
               cnt_d = `ACK_SLOT;
               if (byte_op_w) begin
                  state_d    = LS_WDATA;
                  oe_d       = 1'b1;
                  off_d      = byte_w[6:0];
                  have_cmd_d = 1'b1;
               end else begin
                  state_d = LS_IGNORE;  // block access is not served
                  oe_d    = 1'b0;
               end
            end
            LS_WDATA: begin
               state_d   = LS_DONE;
               oe_d      = 1'b1;
               wr_data_d = byte_w;
               wr_tgl_d  = !wr_tgl_q;
            end
            LS_RDATA: begin
               if (ack_slot_w) begin
                  tx_d  = rd_byte_w;
                  oe_d  = !rd_msb_w;
                  cnt_d = 4'h0;
               end else if (last_bit_w) begin
                  oe_d    = 1'b0;     // release for the host acknowledge
                  state_d = LS_DONE;
               end else begin
                  oe_d  = !tx_q[6];
                  tx_d  = {tx_q[6:0], 1'b0};
                  cnt_d = cnt_q + 4'h1;
               end
            end
            LS_DONE: begin
               oe_d    = 1'b0;
               state_d = LS_IDLE;
            end
            LS_IGNORE: begin
               oe_d = 1'b0;
            end
            default: begin
               oe_d    = 1'b0;
               state_d = LS_IGNORE;
            end
         endcase
      end
   end

   always_ff @(negedge scl_i) begin
      if (link_rst_s) begin
         state_q    <= LS_IDLE;
         cnt_q      <= 4'h0;
         sh_q       <= 8'h00;
         tx_q       <= 8'h00;
         oe_q       <= 1'b0;
         have_cmd_q <= 1'b0;
         off_q      <= 7'h00;
         wr_data_q  <= 8'h00;
         wr_tgl_q   <= 1'b0;
         start_ack_q <= 1'b0;
      end else begin
         start_ack_q <= start_tgl_q;
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         sh_q       <= sh_d;
         tx_q       <= tx_d;
         oe_q       <= oe_d;
         have_cmd_q <= have_cmd_d;
         off_q      <= off_d;
         wr_data_q  <= wr_data_d;
         wr_tgl_q   <= wr_tgl_d;
      end
   end

   // open drain: only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_o = oe_q;

   // ---------------- checks ----------------
   sequence addr_last_s;
      (state_q == LS_ADDR) && last_bit_w && !ack_slot_w && !restart_w;
   endsequence

   sequence ack_pulse_s;
      sda_oe_o ##1 !sda_oe_o;
   endsequence

   AST_RESET_VALUES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (bmc_q == `RST_BUF_MODE) && (pe_q == `RST_PAIR_EN))
      else $error("control registers not at power-up values");

   AST_WRITE_MODE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_mode_w |=> (bmc_q == $past(wr_data_q)) && (mode_o.half_rate_sel == bmc_q[0]))
      else $error("mode register write not applied");

   AST_WRITE_PAIR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_pair_w |=> (pe_q == $past(wr_data_q)) ##1 (diff_pair_en_o == pair_en_w))
      else $error("pair enable write not applied");

   AST_WRITE_OTHER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_pulse_w && off_q > `OFF_PAIR_EN) |=> $stable(bmc_q) && $stable(pe_q))
      else $error("write to unmapped offset changed a register");

   AST_PD_TRISTATE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!pd_n_s && bmc_q[`BM_PD_TRI]) |=> (true_oe_w == 4'h0) && (comp_oe_w == 4'h0))
      else $error("power-down three-state mode left an output driven");

   AST_PD_HELD_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!pd_n_s && !bmc_q[`BM_PD_TRI]) |=>
         (true_oe_w == $past(pair_en_w)) && (comp_oe_w == 4'h0) && (held_w == $past(pair_en_w)))
      else $error("power-down driven mode wrong");

   AST_STOP_TRISTATE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (pd_n_s && !stop_n_s && bmc_q[`BM_STOP_TRI]) |=>
         ((true_oe_w | comp_oe_w) & $past(pair_stoppable_i)) == 4'h0)
      else $error("stopped pair still driven in three-state mode");

   AST_RUN_ENABLES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (pd_n_s && stop_n_s) |=> (true_oe_w == $past(pair_en_w)) && (comp_oe_w == $past(pair_en_w)))
      else $error("running pair enable mismatch");

   AST_ADDR_ACK: assert property (@(negedge scl_i) disable iff (link_rst_s)
      addr_last_s ##0 addr_wr_w |=> ack_pulse_s)
      else $error("own write address not acknowledged for one slot");

   AST_ADDR_MISMATCH: assert property (@(negedge scl_i) disable iff (link_rst_s)
      addr_last_s ##0 (!addr_wr_w && !addr_rd_w) |=> !sda_oe_o [*2])
      else $error("data driven after foreign address");

   AST_BLOCK_CMD: assert property (@(negedge scl_i) disable iff (link_rst_s)
      ((state_q == LS_CMD) && last_bit_w && !restart_w && !byte_op_w) |=>
         !sda_oe_o && (state_q == LS_IGNORE))
      else $error("block command not refused");

   AST_READ_FIRST_BIT: assert property (@(negedge scl_i) disable iff (link_rst_s)
      ((state_q == LS_RDATA) && ack_slot_w && !restart_w) |=> (sda_oe_o == !$past(rd_msb_w)))
      else $error("first read bit wrong");

endmodule // smbus_byte_access_control_regs
`default_nettype wire

// ---- verilog/cbuf_params.svh ----
// constants for the clock buffer serial control registers
`ifndef CBUF_PARAMS_SVH
`define CBUF_PARAMS_SVH

// slave address and direction bit
`define SLAVE_ADDR7    7'h6e
`define DIR_WRITE      1'b0
`define DIR_READ       1'b1

// command code layout
`define CMD_BYTE_OP    7

// register offsets
`define OFF_BUF_MODE   7'h00
`define OFF_PAIR_EN    7'h01

// power-up values
`define RST_BUF_MODE   8'h07
`define RST_PAIR_EN    8'hff

// buffer_mode_control fields
`define BM_PD_TRI      7
`define BM_STOP_TRI    6
`define BM_PLL_BW      2
`define BM_PLL_MODE    1
`define BM_HALF_RATE   0

// output_pair_enable fields
`define PE_PAIR6       6
`define PE_PAIR5       5
`define PE_PAIR2       2
`define PE_PAIR1       1

// bit slots inside one nine-clock byte frame
`define LAST_BIT       4'h7
`define ACK_SLOT       4'h8

`endif

// ---- verilog/cbuf_pkg.sv ----
// types shared by the clock buffer control logic
package cbuf_pkg;

   typedef enum logic [2:0] {
      LS_IDLE,
      LS_IGNORE,
      LS_ADDR,
      LS_CMD,
      LS_WDATA,
      LS_RDATA,
      LS_DONE
   } link_state_e;

   typedef struct packed {
      logic pd_tristate;
      logic stop_tristate;
      logic pll_bandwidth_sel;
      logic pll_mode;
      logic half_rate_sel;
   } mode_ctrl_s;

   typedef struct packed {
      logic true_oe;
      logic comp_oe;
      logic true_held;
      logic drive_2x;
   } pair_drive_s;

endpackage

// ---- verilog/sync2.sv ----
// two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   // clock
   input  wire logic clk_i,
   // level in and out
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
   end

   assign q_o = sync_q;
endmodule // sync2
`default_nettype wire

// ---- verilog/pair_drive.sv ----
// drive state of one differential output pair
`timescale 1ns/1ps
`default_nettype none
module pair_drive
   import cbuf_pkg::*;
(
   // clock and reset
   input  wire logic  sys_clk_i,
   input  wire logic  rst_i,
   // controls
   input  wire logic  pair_en_i,
   input  wire logic  stoppable_i,
   input  wire logic  pd_active_i,
   input  wire logic  stop_active_i,
   input  wire logic  pd_tri_i,
   input  wire logic  stop_tri_i,
   // drive state
   output pair_drive_s drive_o
);
   pair_drive_s drive_d;
   pair_drive_s drive_q;

   always_comb begin
      if (!pair_en_i) begin
         drive_d = '{1'b0, 1'b0, 1'b0, 1'b0};
      end else if (pd_active_i) begin
         // power-down wins over clock stop
         drive_d = '{!pd_tri_i, 1'b0, 1'b1, !pd_tri_i};
      end else if (stop_active_i && stoppable_i) begin
         drive_d = '{!stop_tri_i, 1'b0, 1'b1, 1'b0};
      end else begin
         drive_d = '{1'b1, 1'b1, 1'b0, 1'b0};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         drive_q <= '{1'b0, 1'b0, 1'b0, 1'b0};
      end else begin
         drive_q <= drive_d;
      end
   end

   assign drive_o = drive_q;
endmodule // pair_drive
`default_nettype wire

// ---- sim/smbus_host_model.sv ----
// behavioural SMBus host controller that owns the serial control link
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
   // link clock and open-drain data
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   localparam time HALF = 80ns;

   // clock rests high and data is released outside frames
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // free clocks with data released; the device needs them while held in reset
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #HALF scl_o = 1'b0;
         #HALF scl_o = 1'b1;
      end
   endtask

   // data falls while the clock is high
   task automatic start_cond();
      #HALF sda_low_o = 1'b1;
      #HALF scl_o = 1'b0;
   endtask

   task automatic restart_cond();
      #(HALF/2) sda_low_o = 1'b0;
      #(HALF/2) scl_o = 1'b1;
      start_cond();
   endtask

   task automatic stop_cond();
      #HALF sda_low_o = 1'b1;
      #HALF scl_o = 1'b1;
      #HALF sda_low_o = 1'b0;
      #HALF;
   endtask

   // data changes mid-low, the wire is sampled on the rise
   task automatic clk_bit(input logic b, output logic seen);
      #(HALF/2) sda_low_o = ~b;
      #(HALF/2) scl_o = 1'b1;
      seen = sda_i;
      #HALF scl_o = 1'b0;
   endtask

   // msb first, then the ack slot with data released
   task automatic send_byte(input logic [7:0] b, output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, nak);
   endtask

   task automatic recv_byte(output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
      clk_bit(1'b0, s);
   endtask

   task automatic byte_write(input logic [7:0] addr, cmd, data, output logic [2:0] naks);
      start_cond();
      send_byte(addr, naks[2]);
      send_byte(cmd, naks[1]);
      send_byte(data, naks[0]);
      stop_cond();
   endtask

   task automatic byte_read(input logic [7:0] addr, cmd, output logic [7:0] data,
                            output logic [2:0] naks);
      start_cond();
      send_byte(addr, naks[2]);
      send_byte(cmd, naks[1]);
      restart_cond();
      send_byte(addr | 8'h01, naks[0]);
      recv_byte(data);
      stop_cond();
   endtask
endmodule // smbus_host_model
`default_nettype wire

// ---- sim/tb_smbus_byte_access_control_regs.sv ----
// self-checking bench for the clock buffer serial control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin num_errors++; $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp); end end
module tb_smbus_byte_access_control_regs
   import cbuf_pkg::*;
();
   logic              sys_clk, rst, pd_n, stop_n, oe_seen;
   logic [3:0]        stoppable, pair_en;
   logic              scl, sda_low, sda_out, sda_oe;
   wire               sda_wire;
   mode_ctrl_s        mode;
   pair_drive_s [3:0] drive;
   int                num_errors, n_checks;

   // open-drain data with pull-up
   assign sda_wire = ~sda_low & ~(sda_oe & ~sda_out);

   smbus_host_model smbus_host_model_i (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_wire));

   smbus_byte_access_control_regs smbus_byte_access_control_regs_i (
      .sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_out),
      .sda_oe_o(sda_oe), .power_down_n_i(pd_n), .ref_clock_stop_n_i(stop_n),
      .pair_stoppable_i(stoppable), .mode_o(mode), .diff_pair_en_o(pair_en),
      .pair_drive_o(drive));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sda_oe) oe_seen = 1'b1;

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [7:0] cmd, data, input logic [2:0] naks_exp);
      logic [2:0] naks;
      smbus_host_model_i.byte_write(8'hdc, cmd, data, naks);
      `CHK(naks, naks_exp, "write acks")
      repeat (6) @(negedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] cmd, exp);
      logic [7:0] d;
      logic [2:0] naks;
      smbus_host_model_i.byte_read(8'hdc, cmd, d, naks);
      `CHK(naks, 3'b000, "read acks")
      `CHK(d, exp, "read data")
   endtask

   // pins change off the sampling edge; drive state settles in three cycles
   task automatic pins(input logic pd, stop, input logic [3:0] e0, e1);
      pd_n = pd;
      stop_n = stop;
      repeat (5) @(negedge sys_clk);
      `CHK(drive[0], e0, "stoppable pair")
      `CHK(drive[1], e1, "free pair")
   endtask

   task automatic t_reset();
      `CHK(mode, 5'b00111, "mode at reset")
      `CHK(pair_en, 4'hf, "pairs at reset")
      rd(8'h80, 8'h07);
      rd(8'h81, 8'hff);
      $display("test reset done");
   endtask

   task automatic t_mode();
      wr(8'h80, 8'hc2, 3'b000);
      `CHK(mode, 5'b11010, "mode c2")
      `CHK(mode.pll_bandwidth_sel, 1'b0, "bandwidth")
      `CHK(mode.pll_mode, 1'b1, "loop mode")
      rd(8'h80, 8'hc2);
      wr(8'h80, 8'h3d, 3'b000);
      `CHK(mode, 5'b00101, "mode 3d")
      `CHK(mode.half_rate_sel, 1'b1, "full rate")
      rd(8'h80, 8'h3d);
      $display("test mode done");
   endtask

   task automatic t_pairs();
      wr(8'h81, 8'h99, 3'b000);
      `CHK(pair_en, 4'h0, "reserved only")
      rd(8'h81, 8'h99);
      wr(8'h81, 8'h42, 3'b000);
      `CHK(pair_en, 4'h9, "pairs 6 and 1")
      wr(8'h81, 8'h24, 3'b000);
      `CHK(pair_en, 4'h6, "pairs 5 and 2")
      $display("test pairs done");
   endtask

   task automatic t_refuse();
      logic [2:0] naks;
      oe_seen = 1'b0;
      smbus_host_model_i.byte_write(8'hde, 8'h80, 8'h00, naks);
      `CHK(naks, 3'b111, "foreign address")
      `CHK(oe_seen, 1'b0, "data released")
      smbus_host_model_i.byte_write(8'hdc, 8'h00, 8'h00, naks);
      `CHK(naks, 3'b011, "block command")
      wr(8'h85, 8'h5a, 3'b000);
      rd(8'h85, 8'h00);
      `CHK(mode, 5'b00101, "mode kept")
      $display("test refuse done");
   endtask

   task automatic t_drive();
      wr(8'h81, 8'hff, 3'b000);
      wr(8'h80, 8'h07, 3'b000);
      stoppable = 4'b0101;
      pins(1'b1, 1'b1, 4'hc, 4'hc);
      pins(1'b1, 1'b0, 4'ha, 4'hc);
      pins(1'b0, 1'b1, 4'hb, 4'hb);
      wr(8'h80, 8'hc7, 3'b000);
      pins(1'b0, 1'b0, 4'h2, 4'h2);
      pins(1'b1, 1'b0, 4'h2, 4'hc);
      pins(1'b1, 1'b1, 4'hc, 4'hc);
      wr(8'h81, 8'hfd, 3'b000);
      pins(1'b1, 1'b1, 4'h0, 4'hc);
      $display("test drive done");
   endtask

   initial begin
      rst = 1'b1;
      pd_n = 1'b1;
      stop_n = 1'b1;
      stoppable = 4'h0;
      oe_seen = 1'b0;
      num_errors = 0;
      n_checks = 0;
      // link side resets only while its clock toggles
      fork
         smbus_host_model_i.idle_clocks(4);
      join_none
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      // link reset only lifts after two more link clock rises
      smbus_host_model_i.idle_clocks(3);
      repeat (4) @(negedge sys_clk);
      t_reset();
      t_mode();
      t_pairs();
      t_refuse();
      t_drive();
      finish_test();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      num_errors++;
      $display("ERROR %0t: run did not complete", $time);
      finish_test();
   end
endmodule // tb_smbus_byte_access_control_regs
`default_nettype wire
